// [design/pic_defines.svh]
// constants for the priority interrupt controller
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// register byte offsets
`define OFF_FLAGS       8'h00
`define OFF_ENABLES     8'h0c
`define OFF_PRIO        8'h20
`define OFF_PRIO_END    8'h50
`define OFF_CORE_CTL    8'h50
`define OFF_STATUS      8'h54
`define OFF_TRAP_CTL    8'h58
`define OFF_EXT_CTL     8'h5c
`define OFF_EVT_STAT    8'h60
`define OFF_EVT_EN      8'h64
`define OFF_EVT_CLR     8'h68

// field positions
`define NEST_DIS_BIT    15
`define TIMED_BIT       14
`define ALT_TABLE_BIT   15
`define LEVEL_HI_BIT    3
`define LEVEL_LO_POS    5
`define EVT_ADDR_ERR    0
`define EVT_VEC_DONE    1
`define EVT_TIMED_END   2
`define SRC_EXT0        0
`define SRC_EXT1        16
`define SRC_EXT2        17
`define TRAP_ADDR_ERR   1

// vector space and levels
`define PRI_TABLE_BASE  24'h000004
`define ALT_TABLE_BASE  24'h000084
`define VEC_LO          24'h000004
`define VEC_HI          24'h0000fe
`define SRC_VEC_OFS     6'h08
`define TRAP_VEC_OFS    6'h01
`define TIMED_PASS_LVL  4'h6
`define TRAP_TOP_LVL    4'hf
`define LEVEL_RST       4'h0

// bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// [design/pic_pkg.sv]
// types of the priority interrupt controller
package pic_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_OFFER = 3'h2,
    ST_FETCH = 3'h4
  } core_state_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] idx;
    logic [2:0] level;
  } arb_state_t;

  typedef struct packed {
    logic addr_err;
  } guard_state_t;

  typedef struct packed {
    logic [47:0]  request_flags;
    logic [47:0]  source_enables;
    logic [143:0] source_priority;
    logic [3:0]   cpu_priority_level;
    logic         nesting_disable;
    logic [3:0]   trap_flags;
    logic         alt_table;
    logic [2:0]   edge_select;
    logic [13:0]  timed_cnt;
    logic [3:0]   depth;
    logic [2:0]   evt_status;
    logic [2:0]   evt_enable;
    logic         irq;
    logic [2:0]   pin_s1;
    logic [2:0]   pin_s2;
    logic [2:0]   pin_s3;
    logic [2:0]   pin_level;
    core_state_t  state;
    logic         irq_req;
    logic [23:0]  vec_addr;
    logic [3:0]   irq_level;
    logic         src_is_trap;
    logic [5:0]   src_idx;
    logic         pc_load;
    logic [23:0]  pc_value;
    logic         awready;
    logic         wready;
    logic         aw_held;
    logic         w_held;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } ctl_state_t;

endpackage

// [design/arb_if.sv]
// request and winner signals between controller and arbiter
`timescale 1ns/100ps
interface arb_if;
  logic [47:0]  req;
  logic [143:0] prio;
  logic         valid;
  logic [5:0]   idx;
  logic [2:0]   level;
  modport ctrl (output req, output prio, input valid, input idx, input level);
  modport arb  (input req, input prio, output valid, output idx, output level);
endinterface

// [design/prio_arbiter.sv]
// registered winner search over all maskable sources
`timescale 1ns/100ps
module prio_arbiter (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // requests and winner
  arb_if.arb        a
);
  pic_pkg::arb_state_t r;
  pic_pkg::arb_state_t next_r;
  logic [3:0]          key [48];

  genvar g;
  generate
    for (g = 0; g < 48; g++) begin : g_key
      // level zero never competes
      assign key[g] = (a.req[g] && a.prio[3*g+:3] != 3'h0) ? {1'b1, a.prio[3*g+:3]} : 4'h0;
    end
  endgenerate

  always_comb begin
    next_r = '0;
    // walk downward with >= so the lowest position wins a tie
    for (int i = 47; i >= 0; i--) begin
      if (key[i][3] && key[i][2:0] >= next_r.level) begin
        next_r.valid = 1'b1;
        next_r.idx   = 6'(i);
        next_r.level = key[i][2:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign a.valid = r.valid;
  assign a.idx   = r.idx;
  assign a.level = r.level;

  chk_zero_excluded: assert property (@(posedge aclk) disable iff (!aresetn)
    r.valid |-> r.level != 3'h0)
    else $error("arbiter picked a level zero source");
endmodule

// [design/fetch_guard.sv]
// flags instruction fetches that land in vector space
`timescale 1ns/100ps
`include "pic_defines.svh"
module fetch_guard (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // core fetch
  input  wire logic        fetch_valid,
  input  wire logic [23:0] fetch_addr,
  input  wire logic        fetch_vector,
  // trap pulse
  output logic             addr_err
);
  pic_pkg::guard_state_t r;
  pic_pkg::guard_state_t next_r;

  always_comb begin
    next_r = r;
    // vector reads by the core itself are legal, plain fetches are not
    next_r.addr_err = fetch_valid && !fetch_vector && fetch_addr >= `VEC_LO
                      && fetch_addr <= `VEC_HI;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign addr_err = r.addr_err;

  chk_vector_fetch: assert property (@(posedge aclk) disable iff (!aresetn)
    (fetch_valid && !fetch_vector && fetch_addr <= `VEC_HI && fetch_addr >= `VEC_LO)
    |=> addr_err)
    else $error("vector space fetch did not trap");
endmodule

// [design/priority_interrupt_controller.sv]
// priority interrupt controller with register slave and core handshake
`timescale 1ns/100ps
`include "pic_defines.svh"
module priority_interrupt_controller (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // register bus write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // register bus read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // request sources
  input  wire logic [47:0] periph_irq,
  input  wire logic [2:0]  ext_irq_pin,
  input  wire logic [3:0]  trap_req,
  // core handshake
  output logic             irq_req,
  output logic [23:0]      irq_vec_addr,
  output logic [3:0]       irq_level,
  input  wire logic        irq_ack,
  input  wire logic [23:0] prog_data,
  input  wire logic        prog_data_valid,
  output logic             pc_load,
  output logic [23:0]      pc_value,
  input  wire logic        irq_return,
  input  wire logic [3:0]  return_level,
  // core fetch and timed block
  input  wire logic        fetch_valid,
  input  wire logic [23:0] fetch_addr,
  input  wire logic        fetch_vector,
  input  wire logic        instr_retired,
  input  wire logic        timed_block_start,
  input  wire logic [13:0] timed_block_count,
  // event interrupt
  output logic             irq
);
  pic_pkg::ctl_state_t r;
  pic_pkg::ctl_state_t next_r;
  arb_if               a ();
  logic                addr_err;

  prio_arbiter u_arb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .a       (a)
  );

  fetch_guard u_guard (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .fetch_valid  (fetch_valid),
    .fetch_addr   (fetch_addr),
    .fetch_vector (fetch_vector),
    .addr_err     (addr_err)
  );

  assign a.req  = r.request_flags & r.source_enables;
  assign a.prio = r.source_priority;

  // priority register k as four nibbles, top bit of each zero
  function automatic logic [15:0] prio_word(input logic [143:0] p, input logic [3:0] k);
    logic [15:0] w;
    w = 16'h0000;
    for (int j = 0; j < 4; j++) begin
      w[4*j+:3] = p[3*(4*k+j)+:3];
    end
    return w;
  endfunction

  function automatic logic [31:0] read_reg(input pic_pkg::ctl_state_t s, input logic [7:0] ad,
                                           output logic ok);
    logic [31:0] d;
    d  = 32'h0;
    ok = 1'b1;
    if (ad >= `OFF_PRIO && ad < `OFF_PRIO_END) begin
      d[15:0] = prio_word(s.source_priority, 4'(ad[7:2] - (`OFF_PRIO >> 2)));
    end else begin
      unique case (ad)
        `OFF_FLAGS:        d[15:0] = s.request_flags[15:0];
        `OFF_FLAGS + 8'h4: d[15:0] = s.request_flags[31:16];
        `OFF_FLAGS + 8'h8: d[15:0] = s.request_flags[47:32];
        `OFF_ENABLES:        d[15:0] = s.source_enables[15:0];
        `OFF_ENABLES + 8'h4: d[15:0] = s.source_enables[31:16];
        `OFF_ENABLES + 8'h8: d[15:0] = s.source_enables[47:32];
        `OFF_CORE_CTL: d[`LEVEL_HI_BIT] = s.cpu_priority_level[3];
        `OFF_STATUS:   d[`LEVEL_LO_POS+:3] = s.cpu_priority_level[2:0];
        `OFF_TRAP_CTL: begin
          d[`NEST_DIS_BIT] = s.nesting_disable;
          d[3:0]           = s.trap_flags;
        end
        `OFF_EXT_CTL: begin
          d[`ALT_TABLE_BIT] = s.alt_table;
          d[`TIMED_BIT]     = s.timed_cnt != 14'h0;
          d[2:0]            = s.edge_select;
        end
        `OFF_EVT_STAT: d[2:0] = s.evt_status;
        `OFF_EVT_EN:   d[2:0] = s.evt_enable;
        `OFF_EVT_CLR:  d = 32'h0;
        default:       ok = 1'b0;
      endcase
    end
    return d;
  endfunction

  // candidate, gates and vector address
  logic        trap_any;
  logic [1:0]  trap_idx;
  logic        src_ok;
  logic        cand_ok;
  logic        cand_trap;
  logic [5:0]  cand_idx;
  logic [3:0]  cand_level;
  logic [5:0]  cand_vec;
  logic [23:0] cand_addr;
  logic [2:0]  pin_edge;

  always_comb begin
    trap_any = r.trap_flags != 4'h0;
    trap_idx = r.trap_flags[0] ? 2'h0 : r.trap_flags[1] ? 2'h1 : r.trap_flags[2] ? 2'h2 : 2'h3;
    // recheck live bits: the arbiter answer is one cycle old
    src_ok = a.valid && r.request_flags[a.idx] && r.source_enables[a.idx]
             && r.source_priority[3*a.idx+:3] == a.level;
    cand_trap  = trap_any;
    cand_idx   = trap_any ? {4'h0, trap_idx} : a.idx;
    cand_level = trap_any ? `TRAP_TOP_LVL - {2'h0, trap_idx} : {1'b0, a.level};
    cand_vec   = trap_any ? {4'h0, trap_idx} + `TRAP_VEC_OFS : a.idx + `SRC_VEC_OFS;
    cand_addr  = (r.alt_table ? `ALT_TABLE_BASE : `PRI_TABLE_BASE)
                 + {17'h0, cand_vec, 1'b0};
    cand_ok = (trap_any || src_ok)
              && cand_level > r.cpu_priority_level
              && (r.depth == 4'h0 || !r.nesting_disable)
              && (r.timed_cnt == 14'h0 || cand_level > `TIMED_PASS_LVL);
  end

  assign pin_edge = (r.pin_s2 ~^ r.pin_s3) & (r.pin_s3 ^ r.pin_level)
                    & (r.pin_s3 ^ {3{1'b0}} ^ r.edge_select);

  always_comb begin
    logic        rd_ok;
    logic [15:0] m;
    logic [15:0] v;
    logic [3:0]  k;
    logic [47:0] set;
    logic [2:0]  evt;
    rd_ok = 1'b0;
    next_r = r;
    m = {{8{r.w_strb[1]}}, {8{r.w_strb[0]}}};
    v = r.w_data[15:0] & m;
    k = 4'(r.aw_addr[7:2] - (`OFF_PRIO >> 2));
    evt = 3'h0;
    set = 48'h0;
    next_r.pc_load = 1'b0;

    // pin synchronisers, change counts once stages two and three agree
    next_r.pin_s1 = ext_irq_pin;
    next_r.pin_s2 = r.pin_s1;
    next_r.pin_s3 = r.pin_s2;
    next_r.pin_level = (r.pin_s2 == r.pin_s3) ? r.pin_s3 : r.pin_level;

    // register writes
    if (r.aw_held && r.w_held && !r.bvalid) begin
      next_r.aw_held = 1'b0;
      next_r.w_held  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = `RESP_OKAY;
      if (r.aw_addr >= `OFF_PRIO && r.aw_addr < `OFF_PRIO_END) begin
        for (int j = 0; j < 4; j++) begin
          next_r.source_priority[3*(4*k+j)+:3] = (r.source_priority[3*(4*k+j)+:3]
            & ~m[4*j+:3]) | v[4*j+:3];
        end
      end else begin
        unique case (r.aw_addr)
          `OFF_FLAGS:          next_r.request_flags[15:0]  = (r.request_flags[15:0] & ~m) | v;
          `OFF_FLAGS + 8'h4:   next_r.request_flags[31:16] = (r.request_flags[31:16] & ~m) | v;
          `OFF_FLAGS + 8'h8:   next_r.request_flags[47:32] = (r.request_flags[47:32] & ~m) | v;
          `OFF_ENABLES:        next_r.source_enables[15:0] = (r.source_enables[15:0] & ~m) | v;
          `OFF_ENABLES + 8'h4: next_r.source_enables[31:16] = (r.source_enables[31:16] & ~m) | v;
          `OFF_ENABLES + 8'h8: next_r.source_enables[47:32] = (r.source_enables[47:32] & ~m) | v;
          `OFF_CORE_CTL: if (!r.nesting_disable && m[`LEVEL_HI_BIT]) begin
            next_r.cpu_priority_level[3] = v[`LEVEL_HI_BIT];
          end
          `OFF_STATUS: if (!r.nesting_disable && m[`LEVEL_LO_POS]) begin
            next_r.cpu_priority_level[2:0] = v[`LEVEL_LO_POS+:3];
          end
          `OFF_TRAP_CTL: begin
            if (m[`NEST_DIS_BIT]) next_r.nesting_disable = v[`NEST_DIS_BIT];
            if (m[0]) next_r.trap_flags = v[3:0];
          end
          `OFF_EXT_CTL: begin
            if (m[`ALT_TABLE_BIT]) next_r.alt_table = v[`ALT_TABLE_BIT];
            if (m[0]) next_r.edge_select = v[2:0];
          end
          `OFF_EVT_EN:  if (m[0]) next_r.evt_enable = v[2:0];
          `OFF_EVT_CLR: if (m[0]) next_r.evt_status = r.evt_status & ~v[2:0];
          `OFF_EVT_STAT: next_r.bresp = `RESP_OKAY;
          default:       next_r.bresp = `RESP_SLVERR;
        endcase
      end
    end

    // hardware sets land after software writes so a same-cycle set wins
    set = periph_irq;
    set[`SRC_EXT0] = set[`SRC_EXT0] | pin_edge[0];
    set[`SRC_EXT1] = set[`SRC_EXT1] | pin_edge[1];
    set[`SRC_EXT2] = set[`SRC_EXT2] | pin_edge[2];
    next_r.request_flags = next_r.request_flags | set;
    next_r.trap_flags = next_r.trap_flags | trap_req;
    next_r.trap_flags[`TRAP_ADDR_ERR] = next_r.trap_flags[`TRAP_ADDR_ERR] | addr_err;
    evt[`EVT_ADDR_ERR] = addr_err;

    // timed block counts retired instructions
    if (timed_block_start) begin
      next_r.timed_cnt = timed_block_count;
    end else if (instr_retired && r.timed_cnt != 14'h0) begin
      next_r.timed_cnt = r.timed_cnt - 14'h1;
      evt[`EVT_TIMED_END] = r.timed_cnt == 14'h1;
    end

    if (irq_return) begin
      next_r.cpu_priority_level = return_level;
      next_r.depth = (r.depth != 4'h0) ? r.depth - 4'h1 : r.depth;
    end

    // core handshake
    unique case (r.state)
      pic_pkg::ST_IDLE: begin
        if (cand_ok) begin
          next_r.state = pic_pkg::ST_OFFER;
          next_r.irq_req = 1'b1;
        end
      end
      pic_pkg::ST_OFFER: begin
        if (irq_ack) begin
          next_r.state = pic_pkg::ST_FETCH;
          next_r.irq_req = 1'b0;
          next_r.cpu_priority_level = r.irq_level;
          next_r.depth = r.depth + 4'h1;
        end else if (!cand_ok) begin
          next_r.state = pic_pkg::ST_IDLE;
          next_r.irq_req = 1'b0;
        end
      end
      pic_pkg::ST_FETCH: begin
        if (prog_data_valid) begin
          next_r.state = pic_pkg::ST_IDLE;
          next_r.pc_load = 1'b1;
          next_r.pc_value = prog_data;
          evt[`EVT_VEC_DONE] = 1'b1;
        end
      end
    endcase
    if (next_r.irq_req && !(r.state == pic_pkg::ST_OFFER && irq_ack)) begin
      next_r.vec_addr = cand_addr;
      next_r.irq_level = cand_level;
      next_r.src_is_trap = cand_trap;
      next_r.src_idx = cand_idx;
    end

    // event status: set wins over clear
    next_r.evt_status = next_r.evt_status | evt;
    next_r.irq = |(next_r.evt_status & next_r.evt_enable);

    // write channel capture, either order
    if (awvalid && r.awready) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = awaddr;
    end
    if (wvalid && r.wready) begin
      next_r.w_held = 1'b1;
      next_r.w_data = wdata;
      next_r.w_strb = wstrb;
    end
    if (r.bvalid && bready) next_r.bvalid = 1'b0;
    next_r.awready = !next_r.aw_held && !next_r.bvalid;
    next_r.wready  = !next_r.w_held && !next_r.bvalid;

    // read channel
    if (arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = read_reg(r, araddr, rd_ok);
      next_r.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
    next_r.arready = !next_r.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.state <= pic_pkg::ST_IDLE;
      r.cpu_priority_level <= `LEVEL_RST;
    end else begin
      r <= next_r;
    end
  end

  assign awready      = r.awready;
  assign wready       = r.wready;
  assign bresp        = r.bresp;
  assign bvalid       = r.bvalid;
  assign arready      = r.arready;
  assign rdata        = r.rdata;
  assign rresp        = r.rresp;
  assign rvalid       = r.rvalid;
  assign irq_req      = r.irq_req;
  assign irq_vec_addr = r.vec_addr;
  assign irq_level    = r.irq_level;
  assign pc_load      = r.pc_load;
  assign pc_value     = r.pc_value;
  assign irq          = r.irq;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_vector_arrives;
    r.state == pic_pkg::ST_FETCH && prog_data_valid;
  endsequence

  chk_flag_sticky: assert property ((periph_irq != 48'h0) |=>
    (r.request_flags & $past(periph_irq)) == $past(periph_irq))
    else $error("peripheral request lost");
  chk_enable_gate: assert property ((r.irq_req && !r.src_is_trap) |->
    1'($past(r.source_enables) >> r.src_idx))
    else $error("disabled source offered");
  chk_level_zero: assert property ((r.irq_req && !r.src_is_trap) |->
    3'($past(r.source_priority) >> (3 * r.src_idx)) != 3'h0)
    else $error("level zero source offered");
  chk_nest_block: assert property ((r.nesting_disable && r.depth != 4'h0
    && r.state == pic_pkg::ST_IDLE) |=> !r.irq_req)
    else $error("nested interrupt offered");
  chk_level_readonly: assert property ((r.nesting_disable && !irq_return
    && r.state != pic_pkg::ST_OFFER) |=> $stable(r.cpu_priority_level))
    else $error("cpu level changed while read-only");
  chk_timed_mask: assert property ($rose(r.irq_req) |->
    ($past(r.timed_cnt) == 14'h0 || r.irq_level > `TIMED_PASS_LVL))
    else $error("low level offered during timed block");
  chk_vector_load: assert property (s_vector_arrives |=>
    (pc_load && pc_value == $past(prog_data)) ##1 !pc_load)
    else $error("vector word not loaded");
  chk_vector_range: assert property (r.irq_req |->
    (r.vec_addr >= `VEC_LO && r.vec_addr <= `VEC_HI && !r.vec_addr[0]))
    else $error("vector address outside table");
  chk_above_level: assert property ($rose(r.irq_req) |->
    r.irq_level > $past(r.cpu_priority_level))
    else $error("offer not above cpu level");
endmodule

// [tb/core_model.sv]
// behavioural processor core that takes offers and returns vector words
`timescale 1ns/100ps
module core_model (
  // clock and reset
  input  logic        aclk,
  input  logic        aresetn,
  // offer from the controller
  input  logic        irq_req,
  input  logic [23:0] irq_vec_addr,
  input  logic [3:0]  slow,
  // answer to the controller
  output logic        irq_ack,
  output logic [23:0] prog_data,
  output logic        prog_data_valid
);
  logic        pend;
  logic [3:0]  wait_cnt;
  logic [23:0] vaddr;

  // word at a vector address is 0x400000 or-ed with it, so the pc shows the source
  always_ff @(posedge aclk) begin
    irq_ack <= 1'b0;
    prog_data_valid <= 1'b0;
    prog_data <= ~prog_data;
    if (!aresetn) begin
      pend <= 1'b0;
      wait_cnt <= 4'h0;
      prog_data <= 24'h000000;
    end else if (pend) begin
      prog_data_valid <= 1'b1;
      prog_data <= 24'h400000 | vaddr;
      pend <= 1'b0;
    end else if (irq_req && !irq_ack) begin
      if (wait_cnt == slow) begin
        irq_ack <= 1'b1;
        vaddr <= irq_vec_addr;
        pend <= 1'b1;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

// [tb/testbench.sv]
// self-checking bench of the priority interrupt controller
`timescale 1ns/100ps
module testbench;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
  logic        awready, wready, arready, bvalid, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0]  bresp, rresp, rs;
  logic [47:0] periph_irq;
  logic        irq_req, irq_ack, prog_data_valid, pc_load, irq_return, fetch_valid;
  logic        timed_block_start, irq, instr_retired;
  logic [23:0] irq_vec_addr, prog_data, pc_value, fetch_addr;
  logic [3:0]  irq_level, slow;
  logic [13:0] timed_block_count;
  int          bad_count, checks_done, cycles;

  priority_interrupt_controller dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .periph_irq, .ext_irq_pin(3'h0),
    .trap_req(4'h0), .irq_req, .irq_vec_addr, .irq_level, .irq_ack, .prog_data,
    .prog_data_valid, .pc_load, .pc_value, .irq_return, .return_level(4'h0), .fetch_valid,
    .fetch_addr, .fetch_vector(1'b0), .instr_retired, .timed_block_start,
    .timed_block_count, .irq);
  core_model core_u (.aclk, .aresetn, .irq_req, .irq_vec_addr, .slow, .irq_ack,
    .prog_data, .prog_data_valid);

  always #50 aclk = ~aclk;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // a hang costs a mismatch instead of a stuck run
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_v = rdata;
    rs = rresp;
  endtask

  task automatic pulse(input logic [47:0] m);
    periph_irq <= m;
    @(posedge aclk);
    periph_irq <= 48'h0;
  endtask

  task automatic serve(input logic [23:0] e);
    do @(posedge aclk); while (pc_load !== 1'b1);
    chk("pc_value", {8'h00, pc_value}, {8'h00, e});
  endtask

  // flags cleared before return, else the same source is offered again
  task automatic leave();
    wr(8'h0c, 32'h0);
    wr(8'h00, 32'h0);
    irq_return <= 1'b1;
    @(posedge aclk);
    irq_return <= 1'b0;
  endtask

  task automatic t_bus();
    rd(8'h00);
    chk("flags_reset", rd_v, 32'h0);
    rd(8'h70);
    chk("rresp_unmapped", {30'h0, rs}, 32'h2);
    chk("rdata_unmapped", rd_v, 32'h0);
    wr(8'h70, 32'h1);
    chk("bresp_unmapped", {30'h0, rs}, 32'h2);
  endtask

  task automatic t_serve();
    wr(8'h20, 32'hf000);
    rd(8'h20);
    chk("prio_nibble", rd_v, 32'h7000);
    wr(8'h20, 32'h5000);
    wr(8'h0c, 32'h8);
    slow <= 4'h3;
    pulse(48'h8);
    serve(24'h40001a);
    rd(8'h54);
    chk("cpu_level", rd_v, 32'ha0);
    rd(8'h00);
    chk("flag_held", rd_v, 32'h8);
    repeat (4) @(posedge aclk);
    chk("equal_level", {31'h0, irq_req}, 32'h0);
    wr(8'h58, 32'h8000);
    wr(8'h20, 32'h7000);
    repeat (4) @(posedge aclk);
    chk("nest_blocked", {31'h0, irq_req}, 32'h0);
    wr(8'h58, 32'h0);
    serve(24'h40001a);
    rd(8'h54);
    chk("nest_level", rd_v, 32'he0);
    leave();
    leave();
  endtask

  task automatic t_mask();
    slow <= 4'h0;
    wr(8'h20, 32'h0);
    wr(8'h0c, 32'h8);
    pulse(48'h8);
    repeat (5) @(posedge aclk);
    chk("prio_zero", {31'h0, irq_req}, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h20, 32'h5000);
    repeat (5) @(posedge aclk);
    chk("disabled", {31'h0, irq_req}, 32'h0);
    rd(8'h00);
    chk("flag_disabled", rd_v, 32'h8);
    wr(8'h00, 32'h0);
  endtask

  task automatic t_tie();
    wr(8'h20, 32'h0440);
    wr(8'h0c, 32'h6);
    pulse(48'h6);
    serve(24'h400016);
    rd(8'h54);
    chk("tie_level", rd_v, 32'h80);
    leave();
  endtask

  task automatic t_nest();
    wr(8'h58, 32'h8000);
    wr(8'h54, 32'he0);
    rd(8'h54);
    chk("level_locked", rd_v, 32'h0);
    wr(8'h58, 32'h0);
  endtask

  task automatic t_trap();
    wr(8'h68, 32'h7);
    wr(8'h64, 32'h1);
    fetch_valid <= 1'b1;
    fetch_addr <= 24'h000010;
    @(posedge aclk);
    fetch_valid <= 1'b0;
    serve(24'h400008);
    rd(8'h58);
    chk("trap_flag", {31'h0, rd_v[1]}, 32'h1);
    rd(8'h60);
    chk("event_status", rd_v, 32'h3);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(8'h64, 32'h0);
    @(posedge aclk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(8'h58, 32'h0);
    wr(8'h68, 32'h7);
    rd(8'h60);
    chk("event_cleared", rd_v, 32'h0);
    leave();
  endtask

  task automatic t_timed();
    timed_block_count <= 14'h3;
    timed_block_start <= 1'b1;
    @(posedge aclk);
    timed_block_start <= 1'b0;
    rd(8'h5c);
    chk("timed_bit", {31'h0, rd_v[14]}, 32'h1);
    wr(8'h0c, 32'h2);
    pulse(48'h2);
    repeat (5) @(posedge aclk);
    chk("timed_masked", {31'h0, irq_req}, 32'h0);
    instr_retired <= 1'b1;
    repeat (3) @(posedge aclk);
    instr_retired <= 1'b0;
    serve(24'h400016);
    rd(8'h5c);
    chk("timed_done", {31'h0, rd_v[14]}, 32'h0);
    rd(8'h60);
    chk("timed_event", rd_v, 32'h6);
    leave();
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, irq_return, fetch_valid, timed_block_start, instr_retired} = 7'h00;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    periph_irq = 48'h0;
    fetch_addr = 24'h000000;
    timed_block_count = 14'h0;
    slow = 4'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_bus();
    t_serve();
    t_mask();
    t_tie();
    t_nest();
    t_trap();
    t_timed();
    complete_run();
  end
endmodule
